// file: src/pwr_pkg.sv
/*
  register offsets, bit positions, reset values and control port settings
  for the power enable and thermal shutdown register bank.
  assumes 16-bit registers behind a two-wire control port.
*/
package pwr_pkg;

  // register offsets on the control port
  localparam logic [7:0] OFF_POWER_TWO = 8'h02;
  localparam logic [7:0] OFF_POWER_THREE = 8'h03;
  localparam logic [7:0] OFF_ANTIPOP_BIAS = 8'h39;
  localparam logic [7:0] OFF_SEQUENCER = 8'h46;
  localparam logic [7:0] OFF_PUMP = 8'h4C;
  localparam logic [7:0] OFF_OFFSET_SERVO = 8'h54;

  // power_control_two fields
  localparam int BIT_OVERTEMP_STATUS = 15;
  localparam int BIT_TEMP_SENSOR_ON = 14;
  localparam int BIT_OVERTEMP_OUTPUT_CUT = 13;
  localparam int BIT_SECOND_INPUT_B_AMP_ON = 4;
  // power_control_three fields
  localparam int BIT_SPEAKER_AMP_ON = 8;
  localparam int BIT_LEFT_PHONE_MIXER_ON = 5;
  localparam int BIT_RIGHT_PHONE_MIXER_ON = 4;
  localparam int BIT_SPEAKER_MIXER_ON = 3;
  // other fields
  localparam int BIT_STARTUP_BIAS_ON = 2;
  localparam int BIT_SEQUENCER_ON = 8;
  localparam int BIT_PUMP_ON = 15;
  localparam int BIT_RIGHT_OFFSET_SERVO_ON = 1;
  localparam int BIT_LEFT_OFFSET_SERVO_ON = 0;

  // reset values of single bits
  localparam logic RST_ENABLE_OFF = 1'b0;
  localparam logic RST_TEMP_SENSOR_ON = 1'b1;
  localparam logic RST_OVERTEMP_OUTPUT_CUT = 1'b1;

  // control port device address, value arbitrary
  localparam logic [6:0] PORT_DEVICE_ADDR = 7'h36;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int SYNC_STAGES = 3;

  typedef enum logic [2:0] {
    PS_IDLE = 3'b000,
    PS_RECEIVE = 3'b001,
    PS_ACK = 3'b010,
    PS_SEND = 3'b011,
    PS_MASTER_ACK = 3'b100
  } port_state_type;

  typedef enum logic [1:0] {
    BY_DEVICE = 2'b00,
    BY_POINTER = 2'b01,
    BY_HIGH = 2'b10,
    BY_LOW = 2'b11
  } byte_slot_type;

endpackage : pwr_pkg

// file: src/ctrl_port_slave.sv
/*
  two-wire control port slave: 7-bit device address, 8-bit register pointer,
  16-bit data sent high byte first. assumes scl and sda already filtered.
*/
`timescale 1ns/100ps
module ctrl_port_slave (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // filtered line levels
  input wire logic i_scl,
  input wire logic i_sda,
  // register side and data line enable
  input wire logic [15:0] i_rd_data,
  output logic [7:0] o_reg_addr,
  output logic [15:0] o_wr_data,
  output logic o_wr_stb,
  output logic o_sda_oe
);
  import pwr_pkg::*;

  port_state_type state_r;
  byte_slot_type slot_r;
  logic scl_r, sda_r, got_r, rd_mode_r, lo_next_r, mack_ok_r;
  logic [2:0] bit_r;
  logic [7:0] sh_r, hi_r;

  // line events
  wire start_ev = i_scl & scl_r & sda_r & ~i_sda;
  wire stop_ev = i_scl & scl_r & ~sda_r & i_sda;
  wire scl_rise = i_scl & ~scl_r;
  wire scl_fall = ~i_scl & scl_r;
  wire addr_match = (sh_r[7:1] == PORT_DEVICE_ADDR);
  wire [7:0] next_tx = lo_next_r ? i_rd_data[7:0] : i_rd_data[15:8];

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_r <= PS_IDLE;
      slot_r <= BY_DEVICE;
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      got_r <= 1'b0;
      rd_mode_r <= 1'b0;
      lo_next_r <= 1'b0;
      mack_ok_r <= 1'b0;
      bit_r <= 3'h0;
      sh_r <= 8'h00;
      hi_r <= 8'h00;
      o_reg_addr <= 8'h00;
      o_wr_data <= 16'h0000;
      o_wr_stb <= 1'b0;
      o_sda_oe <= 1'b0;
    end else begin
      scl_r <= i_scl;
      sda_r <= i_sda;
      o_wr_stb <= 1'b0;
      if (start_ev) begin
        state_r <= PS_RECEIVE;
        slot_r <= BY_DEVICE;
        bit_r <= 3'h0;
        got_r <= 1'b0;
        o_sda_oe <= 1'b0;
      end else if (stop_ev) begin
        state_r <= PS_IDLE;
        o_sda_oe <= 1'b0;
      end else begin
        case (state_r)
          PS_RECEIVE: begin
            if (scl_rise) begin
              sh_r <= {sh_r[6:0], i_sda};
              bit_r <= bit_r + 3'h1;
              got_r <= (bit_r == LAST_BIT);
            end else if (scl_fall && got_r) begin
              got_r <= 1'b0;
              state_r <= PS_ACK;
              o_sda_oe <= 1'b1;
              case (slot_r)
                BY_DEVICE: begin
                  rd_mode_r <= sh_r[0];
                  lo_next_r <= 1'b0;
                  slot_r <= BY_POINTER;
                  if (!addr_match) begin
                    state_r <= PS_IDLE;
                    o_sda_oe <= 1'b0;
                  end
                end
                BY_POINTER: begin
                  o_reg_addr <= sh_r;
                  slot_r <= BY_HIGH;
                end
                BY_HIGH: begin
                  hi_r <= sh_r;
                  slot_r <= BY_LOW;
                end
                default: begin
                  o_wr_data <= {hi_r, sh_r};
                  o_wr_stb <= 1'b1;
                  slot_r <= BY_HIGH;
                end
              endcase
            end
          end
          PS_ACK: begin
            if (scl_fall) begin
              bit_r <= 3'h0;
              if (rd_mode_r) begin
                state_r <= PS_SEND;
                o_sda_oe <= ~next_tx[7];
                sh_r <= {next_tx[6:0], 1'b0};
                lo_next_r <= ~lo_next_r;
              end else begin
                state_r <= PS_RECEIVE;
                o_sda_oe <= 1'b0;
              end
            end
          end
          PS_SEND: begin
            if (scl_fall) begin
              if (bit_r == LAST_BIT) begin
                state_r <= PS_MASTER_ACK;
                o_sda_oe <= 1'b0;
              end else begin
                o_sda_oe <= ~sh_r[7];
                sh_r <= {sh_r[6:0], 1'b0};
                bit_r <= bit_r + 3'h1;
              end
            end
          end
          PS_MASTER_ACK: begin
            if (scl_rise) begin
              mack_ok_r <= ~i_sda;
            end else if (scl_fall) begin
              bit_r <= 3'h0;
              if (mack_ok_r) begin
                state_r <= PS_SEND;
                o_sda_oe <= ~next_tx[7];
                sh_r <= {next_tx[6:0], 1'b0};
                lo_next_r <= ~lo_next_r;
              end else begin
                state_r <= PS_IDLE;
              end
            end
          end
          default: begin
            o_sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule : ctrl_port_slave

// file: src/power_enable_thermal_shutdown.sv
/*
  power enable registers for the analogue path and the thermal shutdown
  monitor, reached over the two-wire control port. assumes an analogue
  comparator pin that is high while the die is above the trip temperature.
*/
// Notes on behaviour
// - power two bit 4 enables second input b amplifier, reset 0
// - power three bit 8 speaker amp, bit 3 speaker mixer, reset 0
// - power three bit 5 left, bit 4 right phone mixer, reset 0
// - register 39h bit 2 switches start-up bias generator, reset 0
// - register 54h bit 1 right, bit 0 left offset servo, reset 0
// - power two bit 15 reads over-temperature status, read only
// - over-temperature flagged near 150 C only while sensor enabled
// - power two bit 14 enables temperature sensor, reset 1
// - bit 13 set, sensor on, over-temperature forces speaker output off
`timescale 1ns/100ps
module power_enable_thermal_shutdown (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RESET,
  // control port pins
  input wire logic I_SCL,
  input wire logic I_SDA,
  output logic O_SDA_OUT,
  output logic O_SDA_OE,
  // thermal comparator
  input wire logic I_OVERTEMP_SENSE,
  // analogue enables
  output logic O_SECOND_INPUT_B_AMP_ON,
  output logic O_SPEAKER_AMP_ON,
  output logic O_SPEAKER_MIXER_ON,
  output logic O_LEFT_PHONE_MIXER_ON,
  output logic O_RIGHT_PHONE_MIXER_ON,
  output logic O_STARTUP_BIAS_ON,
  output logic O_SEQUENCER_ON,
  output logic O_PUMP_ON,
  output logic O_RIGHT_OFFSET_SERVO_ON,
  output logic O_LEFT_OFFSET_SERVO_ON,
  output logic O_TEMP_SENSOR_ON,
  // speaker driver
  output logic O_SPEAKER_OUT_ON,
  output logic O_OVERTEMP_CUT
);
  import pwr_pkg::*;

  // pin synchronisers: scl, sda, overtemp
  logic [2:0] pin_in;
  logic [2:0] filt_r;
  logic [SYNC_STAGES-1:0] sync_r [3];
  assign pin_in = {I_OVERTEMP_SENSE, I_SDA, I_SCL};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
          sync_r[g] <= '0;
          filt_r[g] <= 1'b0;
        end else begin
          sync_r[g] <= {sync_r[g][SYNC_STAGES-2:0], pin_in[g]};
          if (sync_r[g][1] == sync_r[g][2]) begin
            filt_r[g] <= sync_r[g][2];
          end
        end
      end
    end
  endgenerate

  wire scl_f = filt_r[0];
  wire sda_f = filt_r[1];
  wire ot_f = filt_r[2];

  // control port
  logic [7:0] reg_addr;
  logic [15:0] wr_data;
  logic wr_stb;
  logic [15:0] rd_data;

  ctrl_port_slave u_port (
    .i_clk(I_CLK),
    .i_reset(I_RESET),
    .i_scl(scl_f),
    .i_sda(sda_f),
    .i_rd_data(rd_data),
    .o_reg_addr(reg_addr),
    .o_wr_data(wr_data),
    .o_wr_stb(wr_stb),
    .o_sda_oe(O_SDA_OE)
  );
  assign O_SDA_OUT = 1'b0;

  // register state
  logic in_b_r, spk_amp_r, spk_mix_r, lmix_r, rmix_r, bias_r;
  logic seq_r, pump_r, rservo_r, lservo_r, tsens_r, cut_opt_r, status_r;

  // write decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  wire wr_two = wr_stb & hit(reg_addr, OFF_POWER_TWO);
  wire wr_three = wr_stb & hit(reg_addr, OFF_POWER_THREE);
  wire wr_bias = wr_stb & hit(reg_addr, OFF_ANTIPOP_BIAS);
  wire wr_seq = wr_stb & hit(reg_addr, OFF_SEQUENCER);
  wire wr_pump = wr_stb & hit(reg_addr, OFF_PUMP);
  wire wr_servo = wr_stb & hit(reg_addr, OFF_OFFSET_SERVO);
  wire cut_now = status_r & tsens_r & cut_opt_r;

  // read mux, unmapped reads return zero
  wire [15:0] rd_two = 16'(status_r) << BIT_OVERTEMP_STATUS | 16'(tsens_r) << BIT_TEMP_SENSOR_ON
                     | 16'(cut_opt_r) << BIT_OVERTEMP_OUTPUT_CUT | 16'(in_b_r) << BIT_SECOND_INPUT_B_AMP_ON;
  wire [15:0] rd_three = 16'(spk_amp_r) << BIT_SPEAKER_AMP_ON | 16'(lmix_r) << BIT_LEFT_PHONE_MIXER_ON
                       | 16'(rmix_r) << BIT_RIGHT_PHONE_MIXER_ON | 16'(spk_mix_r) << BIT_SPEAKER_MIXER_ON;
  assign rd_data = hit(reg_addr, OFF_POWER_TWO) ? rd_two
                 : hit(reg_addr, OFF_POWER_THREE) ? rd_three
                 : hit(reg_addr, OFF_ANTIPOP_BIAS) ? 16'(bias_r) << BIT_STARTUP_BIAS_ON
                 : hit(reg_addr, OFF_SEQUENCER) ? 16'(seq_r) << BIT_SEQUENCER_ON
                 : hit(reg_addr, OFF_PUMP) ? 16'(pump_r) << BIT_PUMP_ON
                 : hit(reg_addr, OFF_OFFSET_SERVO) ? (16'(rservo_r) << BIT_RIGHT_OFFSET_SERVO_ON
                                                    | 16'(lservo_r) << BIT_LEFT_OFFSET_SERVO_ON)
                 : 16'h0000;

  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      in_b_r <= RST_ENABLE_OFF;
      tsens_r <= RST_TEMP_SENSOR_ON;
      cut_opt_r <= RST_OVERTEMP_OUTPUT_CUT;
    end else if (wr_two) begin
      in_b_r <= wr_data[BIT_SECOND_INPUT_B_AMP_ON];
      tsens_r <= wr_data[BIT_TEMP_SENSOR_ON];
      cut_opt_r <= wr_data[BIT_OVERTEMP_OUTPUT_CUT];
    end
  end

  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      spk_amp_r <= RST_ENABLE_OFF;
      spk_mix_r <= RST_ENABLE_OFF;
      lmix_r <= RST_ENABLE_OFF;
      rmix_r <= RST_ENABLE_OFF;
    end else if (wr_three) begin
      spk_amp_r <= wr_data[BIT_SPEAKER_AMP_ON];
      spk_mix_r <= wr_data[BIT_SPEAKER_MIXER_ON];
      lmix_r <= wr_data[BIT_LEFT_PHONE_MIXER_ON];
      rmix_r <= wr_data[BIT_RIGHT_PHONE_MIXER_ON];
    end
  end

  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      bias_r <= RST_ENABLE_OFF;
      seq_r <= RST_ENABLE_OFF;
      pump_r <= RST_ENABLE_OFF;
      rservo_r <= RST_ENABLE_OFF;
      lservo_r <= RST_ENABLE_OFF;
    end else begin
      if (wr_bias) bias_r <= wr_data[BIT_STARTUP_BIAS_ON];
      if (wr_seq) seq_r <= wr_data[BIT_SEQUENCER_ON];
      if (wr_pump) pump_r <= wr_data[BIT_PUMP_ON];
      if (wr_servo) begin
        rservo_r <= wr_data[BIT_RIGHT_OFFSET_SERVO_ON];
        lservo_r <= wr_data[BIT_LEFT_OFFSET_SERVO_ON];
      end
    end
  end

  // live status, writes ignored
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      status_r <= 1'b0;
    end else begin
      status_r <= tsens_r & ot_f;
    end
  end

  // output flops
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_SECOND_INPUT_B_AMP_ON <= 1'b0;
      O_SPEAKER_AMP_ON <= 1'b0;
      O_SPEAKER_MIXER_ON <= 1'b0;
      O_LEFT_PHONE_MIXER_ON <= 1'b0;
      O_RIGHT_PHONE_MIXER_ON <= 1'b0;
      O_STARTUP_BIAS_ON <= 1'b0;
      O_SEQUENCER_ON <= 1'b0;
      O_PUMP_ON <= 1'b0;
      O_RIGHT_OFFSET_SERVO_ON <= 1'b0;
      O_LEFT_OFFSET_SERVO_ON <= 1'b0;
      O_TEMP_SENSOR_ON <= 1'b0;
      O_SPEAKER_OUT_ON <= 1'b0;
      O_OVERTEMP_CUT <= 1'b0;
    end else begin
      O_SECOND_INPUT_B_AMP_ON <= in_b_r;
      O_SPEAKER_AMP_ON <= spk_amp_r;
      O_SPEAKER_MIXER_ON <= spk_mix_r;
      O_LEFT_PHONE_MIXER_ON <= lmix_r;
      O_RIGHT_PHONE_MIXER_ON <= rmix_r;
      O_STARTUP_BIAS_ON <= bias_r;
      O_SEQUENCER_ON <= seq_r;
      O_PUMP_ON <= pump_r;
      O_RIGHT_OFFSET_SERVO_ON <= rservo_r;
      O_LEFT_OFFSET_SERVO_ON <= lservo_r;
      O_TEMP_SENSOR_ON <= tsens_r;
      O_SPEAKER_OUT_ON <= spk_amp_r & ~cut_now;
      O_OVERTEMP_CUT <= cut_now;
    end
  end

  // checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);

  property p_in_b;
    wr_two |-> ##2 O_SECOND_INPUT_B_AMP_ON == $past(wr_data[BIT_SECOND_INPUT_B_AMP_ON], 2);
  endproperty
  a_in_b: assert property (p_in_b) else $error("second input b enable wrong");

  property p_speaker;
    wr_three |=> (spk_amp_r == $past(wr_data[BIT_SPEAKER_AMP_ON]))
      && (spk_mix_r == $past(wr_data[BIT_SPEAKER_MIXER_ON]));
  endproperty
  a_speaker: assert property (p_speaker) else $error("speaker enables wrong");

  property p_phone_mix;
    wr_three |-> ##2 (O_LEFT_PHONE_MIXER_ON == $past(wr_data[BIT_LEFT_PHONE_MIXER_ON], 2))
      && (O_RIGHT_PHONE_MIXER_ON == $past(wr_data[BIT_RIGHT_PHONE_MIXER_ON], 2));
  endproperty
  a_phone_mix: assert property (p_phone_mix) else $error("phone mixer enables wrong");

  property p_bias;
    !wr_bias [*2] |-> O_STARTUP_BIAS_ON == $past(bias_r);
  endproperty
  a_bias: assert property (p_bias) else $error("start-up bias enable wrong");

  property p_servo;
    wr_servo |-> ##2 (O_RIGHT_OFFSET_SERVO_ON == $past(wr_data[BIT_RIGHT_OFFSET_SERVO_ON], 2))
      && (O_LEFT_OFFSET_SERVO_ON == $past(wr_data[BIT_LEFT_OFFSET_SERVO_ON], 2));
  endproperty
  a_servo: assert property (p_servo) else $error("offset servo enables wrong");

  property p_status_ro;
    wr_two |=> status_r == $past(tsens_r & ot_f);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status bit took a write");

  property p_sensor_gate;
    !tsens_r |=> !status_r ##1 !O_OVERTEMP_CUT;
  endproperty
  a_sensor_gate: assert property (p_sensor_gate) else $error("status set with sensor off");

  property p_sensor_on;
    wr_two |=> tsens_r == $past(wr_data[BIT_TEMP_SENSOR_ON]) ##1 O_TEMP_SENSOR_ON == tsens_r;
  endproperty
  a_sensor_on: assert property (p_sensor_on) else $error("sensor enable wrong");

  property p_cut;
    status_r && tsens_r && cut_opt_r |=> !O_SPEAKER_OUT_ON && O_OVERTEMP_CUT;
  endproperty
  a_cut: assert property (p_cut) else $error("speaker not cut on overtemp");

  property p_pump_seq;
    (wr_pump |-> ##2 O_PUMP_ON == $past(wr_data[BIT_PUMP_ON], 2))
      and (wr_seq |-> ##2 O_SEQUENCER_ON == $past(wr_data[BIT_SEQUENCER_ON], 2));
  endproperty
  a_pump_seq: assert property (p_pump_seq) else $error("pump or sequencer enable wrong");

  property p_cv_cut;
    $rose(O_OVERTEMP_CUT);
  endproperty
  c_cut: cover property (p_cv_cut);

  property p_cv_write;
    wr_three && wr_data[BIT_SPEAKER_AMP_ON];
  endproperty
  c_write: cover property (p_cv_write);

  property p_cv_read;
    u_port.state_r == PS_SEND && hit(reg_addr, OFF_POWER_TWO);
  endproperty
  c_read: cover property (p_cv_read);

endmodule : power_enable_thermal_shutdown

// file: verif/test_power_enable_thermal_shutdown.sv
/*
  self-checking bench for the power enable and thermal shutdown register bank.
  assumes the two-wire port of the design, device address from the package,
  and an open-drain data line that the bench resolves itself.
*/
`timescale 1ns/100ps
`define CHK(e, a) begin exp_q.push_back(e); act_q.push_back(a); end
module test_power_enable_thermal_shutdown;
  import pwr_pkg::*;
  logic I_CLK, I_RESET, I_SCL, sda_m, I_OVERTEMP_SENSE;
  logic O_SDA_OUT, O_SDA_OE, O_SECOND_INPUT_B_AMP_ON, O_SPEAKER_AMP_ON, O_SPEAKER_MIXER_ON;
  logic O_LEFT_PHONE_MIXER_ON, O_RIGHT_PHONE_MIXER_ON, O_STARTUP_BIAS_ON, O_SEQUENCER_ON, O_PUMP_ON;
  logic O_RIGHT_OFFSET_SERVO_ON, O_LEFT_OFFSET_SERVO_ON, O_TEMP_SENSOR_ON, O_SPEAKER_OUT_ON, O_OVERTEMP_CUT;
  wire sda_w = sda_m & (O_SDA_OE ? O_SDA_OUT : 1'b1);
  wire [15:0] outs = {3'h0, O_SPEAKER_OUT_ON, O_OVERTEMP_CUT, O_TEMP_SENSOR_ON, O_SECOND_INPUT_B_AMP_ON,
    O_SPEAKER_AMP_ON, O_SPEAKER_MIXER_ON, O_LEFT_PHONE_MIXER_ON, O_RIGHT_PHONE_MIXER_ON, O_STARTUP_BIAS_ON,
    O_SEQUENCER_ON, O_PUMP_ON, O_RIGHT_OFFSET_SERVO_ON, O_LEFT_OFFSET_SERVO_ON};
  logic [15:0] exp_q[$];
  logic [15:0] act_q[$];
  logic [15:0] m2, m3, m39, m46, m4c, m54, rdv;
  logic [7:0] offs[6];
  logic [15:0] masks[6];
  int err_count, comparisons, cycles, seed, i, k;

  power_enable_thermal_shutdown dut (
    .I_CLK(I_CLK), .I_RESET(I_RESET), .I_SCL(I_SCL), .I_SDA(sda_w), .O_SDA_OUT(O_SDA_OUT),
    .O_SDA_OE(O_SDA_OE), .I_OVERTEMP_SENSE(I_OVERTEMP_SENSE),
    .O_SECOND_INPUT_B_AMP_ON(O_SECOND_INPUT_B_AMP_ON), .O_SPEAKER_AMP_ON(O_SPEAKER_AMP_ON),
    .O_SPEAKER_MIXER_ON(O_SPEAKER_MIXER_ON), .O_LEFT_PHONE_MIXER_ON(O_LEFT_PHONE_MIXER_ON),
    .O_RIGHT_PHONE_MIXER_ON(O_RIGHT_PHONE_MIXER_ON), .O_STARTUP_BIAS_ON(O_STARTUP_BIAS_ON),
    .O_SEQUENCER_ON(O_SEQUENCER_ON), .O_PUMP_ON(O_PUMP_ON), .O_RIGHT_OFFSET_SERVO_ON(O_RIGHT_OFFSET_SERVO_ON),
    .O_LEFT_OFFSET_SERVO_ON(O_LEFT_OFFSET_SERVO_ON), .O_TEMP_SENSOR_ON(O_TEMP_SENSOR_ON),
    .O_SPEAKER_OUT_ON(O_SPEAKER_OUT_ON), .O_OVERTEMP_CUT(O_OVERTEMP_CUT)
  );

  initial begin
    I_CLK = 1'b0;
    forever #50 I_CLK = ~I_CLK;
  end

  // result watcher: oldest note against oldest result
  initial begin
    forever begin
      @(negedge I_CLK);
      while (act_q.size() > 0) begin
        comparisons++;
        if (act_q[0] !== exp_q[0]) begin
          err_count++;
          $display("Error at %0t: got %h expected %h", $time, act_q[0], exp_q[0]);
        end
        void'(act_q.pop_front());
        void'(exp_q.pop_front());
      end
    end
  end

  always @(posedge I_CLK) begin
    cycles++;
    if (cycles == 98000) begin
      err_count++;
      $display("Error at %0t: run did not finish", $time);
      finish_test();
    end
  end

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  task automatic half();
    repeat (8) @(negedge I_CLK);
  endtask : half

  task automatic port_start();
    sda_m = 1'b1;
    half();
    I_SCL = 1'b1;
    half();
    sda_m = 1'b0;
    half();
    I_SCL = 1'b0;
  endtask : port_start

  task automatic port_stop();
    half();
    sda_m = 1'b0;
    half();
    I_SCL = 1'b1;
    half();
    sda_m = 1'b1;
    half();
  endtask : port_stop

  // eight bits then the acknowledge bit; mack 1 releases the line
  task automatic port_byte(input logic [7:0] d, input logic mack, output logic [7:0] r, output logic ack);
    for (int b = 8; b >= 0; b--) begin
      half();
      sda_m = (b == 0) ? mack : d[b-1];
      half();
      I_SCL = 1'b1;
      half();
      if (b == 0) ack = sda_w;
      else r[b-1] = sda_w;
      I_SCL = 1'b0;
    end
  endtask : port_byte

  task automatic wr(input logic [7:0] ptr, input logic [15:0] d);
    logic [7:0] r;
    logic a;
    port_start();
    port_byte({PORT_DEVICE_ADDR, 1'b0}, 1'b1, r, a);
    `CHK(16'h0000, {15'h0, a})
    port_byte(ptr, 1'b1, r, a);
    port_byte(d[15:8], 1'b1, r, a);
    port_byte(d[7:0], 1'b1, r, a);
    port_stop();
  endtask : wr

  task automatic rd(input logic [7:0] ptr, output logic [15:0] d);
    logic [7:0] r;
    logic a;
    port_start();
    port_byte({PORT_DEVICE_ADDR, 1'b0}, 1'b1, r, a);
    port_byte(ptr, 1'b1, r, a);
    port_start();
    port_byte({PORT_DEVICE_ADDR, 1'b1}, 1'b1, r, a);
    port_byte(8'hFF, 1'b0, d[15:8], a);
    port_byte(8'hFF, 1'b1, d[7:0], a);
    port_stop();
  endtask : rd

  function automatic logic [15:0] exp_outs();
    logic cut;
    cut = I_OVERTEMP_SENSE & m2[14] & m2[13];
    return {3'h0, m3[8] & ~cut, cut, m2[14], m2[4], m3[8], m3[3], m3[5], m3[4], m39[2], m46[8], m4c[15],
      m54[1], m54[0]};
  endfunction : exp_outs

  function automatic logic [15:0] exp_reg(input int n);
    logic [15:0] v[6];
    v = '{m2, m3, m39, m46, m4c, m54};
    if (n == 0) return (m2 & 16'h6010) | {I_OVERTEMP_SENSE & m2[14], 15'h0};
    return v[n] & masks[n];
  endfunction : exp_reg

  task automatic reset_dut();
    I_RESET = 1'b1;
    repeat (8) @(negedge I_CLK);
    I_RESET = 1'b0;
    m2 = 16'h6000;
    {m3, m39, m46, m4c, m54} = '0;
    half();
  endtask : reset_dut

  task automatic check_all();
    `CHK(exp_outs(), outs)
    for (k = 0; k < 6; k++) begin
      rd(offs[k], rdv);
      `CHK(exp_reg(k), rdv)
    end
  endtask : check_all

  task automatic put(input int n, input logic [15:0] d);
    wr(offs[n], d);
    case (n)
      0: m2 = d;
      1: m3 = d;
      2: m39 = d;
      3: m46 = d;
      4: m4c = d;
      default: m54 = d;
    endcase
  endtask : put

  initial begin
    logic [7:0] r;
    logic a;
    I_RESET = 1'b1;
    I_SCL = 1'b1;
    sda_m = 1'b1;
    I_OVERTEMP_SENSE = 1'b0;
    err_count = 0;
    comparisons = 0;
    cycles = 0;
    seed = 12726;
    offs = '{OFF_POWER_TWO, OFF_POWER_THREE, OFF_ANTIPOP_BIAS, OFF_SEQUENCER, OFF_PUMP, OFF_OFFSET_SERVO};
    masks = '{16'h6010, 16'h0138, 16'h0004, 16'h0100, 16'h8000, 16'h0003};
    reset_dut();
    check_all();
    // random values; speaker held off while sensor bits change
    for (i = 0; i < 2; i++) begin
      put(1, 16'h0000);
      for (k = 0; k < 6; k++) put(k, 16'($random(seed)));
      check_all();
    end
    // all enables set at once, status bit write ignored
    put(1, 16'h0000);
    put(0, 16'hFFFF);
    for (k = 1; k < 6; k++) put(k, 16'hFFFF);
    check_all();
    // unmapped place: write dropped, read zero
    wr(8'h10, 16'hFFFF);
    rd(8'h10, rdv);
    `CHK(16'h0000, rdv)
    // wrong device address gets no acknowledge
    port_start();
    port_byte(8'h70, 1'b1, r, a);
    port_stop();
    `CHK(16'h0001, {15'h0, a})
    // over-temperature with cut option set
    put(1, 16'h0000);
    put(0, 16'h6000);
    put(1, 16'h0100);
    I_OVERTEMP_SENSE = 1'b1;
    repeat (12) @(negedge I_CLK);
    check_all();
    I_OVERTEMP_SENSE = 1'b0;
    repeat (12) @(negedge I_CLK);
    check_all();
    I_OVERTEMP_SENSE = 1'b1;
    // cut option off: status stays but speaker stays on
    put(1, 16'h0000);
    put(0, 16'h4000);
    put(1, 16'h0100);
    check_all();
    // sensor off: no status, no cut
    put(1, 16'h0000);
    put(0, 16'h2000);
    put(1, 16'h0100);
    check_all();
    I_OVERTEMP_SENSE = 1'b0;
    // second reset in mid-run
    reset_dut();
    check_all();
    repeat (4) @(negedge I_CLK);
    finish_test();
  end
endmodule : test_power_enable_thermal_shutdown
